// *** mac_frame_control_config.sv ***
// mac frame control: register file, transmit framing and receive checking
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mac_frame_control_config
	import mac_frame_control_pkg::*;
#(
	parameter logic [15:0] MAX_FRAME_RESET = MAX_FRAME_DEFAULT,
	parameter int          DEFER_LIMIT     = DEFER_LIMIT_DEFAULT,
	parameter int          SLOT_CYCLES     = SLOT_CYCLES_DEFAULT
) (
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        tx_valid_i,
	input  wire logic [7:0]  tx_data_i,
	input  wire logic        tx_last_i,
	output logic             tx_ready_o,
	input  wire logic        carrier_i,
	input  wire logic        collision_i,
	input  wire logic        backpressure_i,
	input  wire logic        pause_send_i,
	output logic             phy_tx_valid_o,
	output logic      [7:0]  phy_tx_data_o,
	output logic             phy_tx_last_o,
	output logic             phy_tx_err_o,
	output logic             tx_status_valid_o,
	output logic      [7:0]  tx_status_o,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_last_i,
	output logic             rx_out_valid_o,
	output logic      [7:0]  rx_out_data_o,
	output logic             rx_out_last_o,
	output logic             rx_out_abort_o,
	output logic             rx_status_valid_o,
	output logic      [7:0]  rx_status_o,
	output logic             pause_frame_req_o,
	output logic             full_duplex_o
);

	if (DEFER_LIMIT < 1 || DEFER_LIMIT > 1048575 ||
			SLOT_CYCLES < 1 || SLOT_CYCLES > 1024) begin : g_bad_param
		$error("mac_frame_control_config: parameter out of range");
	end

	typedef struct packed {
		logic [7:0]  c1;
		logic [7:0]  c3;
		logic [7:0]  c4;
		logic [15:0] mfl;
		logic [6:0]  b2b;
		logic [6:0]  gapl;
		logic [6:0]  gaph;
		logic [3:0]  rlim;
		logic [5:0]  cwin;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		tx_state_t   ts;
		logic        tready;
		logic        ptx_valid;
		logic [7:0]  ptx_data;
		logic        ptx_last;
		logic        ptx_err;
		logic [15:0] tcnt;
		logic [31:0] tcrc;
		logic [15:0] ttype;
		logic [15:0] ttarget;
		logic        tcoll;
		logic        tsv_valid;
		logic [7:0]  tsv;
		logic [19:0] wait_cnt;
		logic [1:0]  crc_idx;
		logic [3:0]  attempts;
		logic [9:0]  lfsr;
		logic        ract;
		logic        rdrop;
		logic        rgood;
		logic [15:0] rcnt;
		logic [31:0] rcrc;
		logic [15:0] rtype;
		logic [15:0] rop;
		logic [15:0] rquanta;
		logic        rout_valid;
		logic [7:0]  rout_data;
		logic        rout_last;
		logic        rout_abort;
		logic        rsv_valid;
		logic [7:0]  rsv;
		logic [21:0] pause_cnt;
		logic        pause_req;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic        full_dx;
	logic [15:0] hdr_len;
	logic [19:0] ipg_len;
	logic [19:0] bo_len;
	logic [3:0]  bo_exp;
	logic [9:0]  bo_mask;
	logic [31:0] rd_data;
	logic        hit;
	logic        wr;
	logic [15:0] dlen;
	logic [15:0] tgt;
	logic        fin;
	logic        coll_go;
	logic        go_ipg;

	// reflected crc-32, one byte lsb first
	function automatic logic [31:0] crc_byte(input logic [31:0] c,
			input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// dlen counts frame bytes after any vendor header
	function automatic logic len_mismatch(input logic [15:0] field,
			input logic [15:0] dlen_f, input logic fcs_in);
		logic [15:0] pay;
		pay = dlen_f - MAC_HDR_BYTES - (fcs_in ? FCS_BYTES : 16'h0000);
		return (dlen_f >= LEN_CHECK_MIN) && (field <= LENGTH_MAX) &&
			((field > pay) || ((pay > PAYLOAD_MIN) && (field != pay)));
	endfunction

	function automatic logic [15:0] pad_target(input logic [2:0] cfg,
			input logic vlan);
		case (cfg)
			PAD_64_A, PAD_64_B: return FRAME_MIN_TAG;
			PAD_VLAN: return vlan ? FRAME_MIN_TAG : FRAME_MIN;
			PAD_60: return FRAME_MIN;
			default: return 16'h0000;
		endcase
	endfunction

	always_comb begin
		s_d = s_q;
		dlen = 16'h0000;
		tgt = 16'h0000;
		fin = 1'b0;
		coll_go = 1'b0;
		go_ipg = 1'b0;
		full_dx = s_q.c3[BIT_DUPLEX];
		hdr_len = s_q.c3[BIT_VENDOR_HDR] ? HDR_BYTES : 16'h0000;
		ipg_len = 20'(s_q.b2b) + (full_dx ? GAP_OFS_FULL : GAP_OFS_HALF);
		bo_exp = (s_q.attempts > BACKOFF_CAP) ? BACKOFF_CAP : s_q.attempts;
		bo_mask = 10'h3FF >> (BACKOFF_CAP - bo_exp);
		if (s_q.c4[BIT_NO_BACKOFF] ||
				(s_q.c4[BIT_BP_NO_BKOFF] && backpressure_i))
			bo_len = 20'h00000;
		else
			bo_len = 20'(s_q.lfsr & bo_mask) * 20'(SLOT_CYCLES);

		s_d.ptx_valid = 1'b0;
		s_d.ptx_last = 1'b0;
		s_d.ptx_err = 1'b0;
		s_d.tsv_valid = 1'b0;
		s_d.rout_valid = 1'b0;
		s_d.rout_last = 1'b0;
		s_d.rout_abort = 1'b0;
		s_d.rsv_valid = 1'b0;
		s_d.lfsr = {s_q.lfsr[8:0], s_q.lfsr[9] ^ s_q.lfsr[6]};
		s_d.pause_req = pause_send_i && s_q.c1[BIT_PAUSE_TX] && full_dx;

		// register read mux; unused bits stay zero
		hit = 1'b1;
		case (paddr_i)
			OFF_CTRL_ONE:    rd_data = {24'h000000, s_q.c1};
			OFF_CTRL_THREE:  rd_data = {24'h000000, s_q.c3};
			OFF_CTRL_FOUR:   rd_data = {24'h000000, s_q.c4};
			OFF_MAX_FRAME:   rd_data = {16'h0000, s_q.mfl};
			OFF_B2B_GAP:     rd_data = {25'h0000000, s_q.b2b};
			OFF_GAP_LOW:     rd_data = {25'h0000000, s_q.gapl};
			OFF_GAP_HIGH:    rd_data = {25'h0000000, s_q.gaph};
			OFF_RETRY_LIMIT: rd_data = {28'h0000000, s_q.rlim};
			OFF_COLL_WINDOW: rd_data = {26'h0000000, s_q.cwin};
			OFF_STATUS:      rd_data = {24'h000000, s_q.attempts, 1'b0,
				s_q.ract, s_q.ts != TX_IDLE, s_q.pause_cnt != 22'h000000};
			default: begin
				rd_data = 32'h00000000;
				hit = 1'b0;
			end
		endcase
		wr = psel_i && penable_i && s_q.pready && pwrite_i && hit;
		if (psel_i && !penable_i) begin
			s_d.pready = 1'b1;
			s_d.prdata = rd_data;
			s_d.pslverr = !hit;
		end else if (psel_i && penable_i && s_q.pready) begin
			s_d.pready = 1'b0;
			s_d.pslverr = 1'b0;
		end
		if (wr) begin
			case (paddr_i)
				OFF_CTRL_ONE:    s_d.c1 = pwdata_i[7:0] & CTRL_ONE_WMASK;
				OFF_CTRL_THREE:  s_d.c3 = pwdata_i[7:0];
				OFF_CTRL_FOUR:   s_d.c4 = pwdata_i[7:0] & CTRL_FOUR_WMASK;
				OFF_MAX_FRAME:   s_d.mfl = pwdata_i[15:0];
				OFF_B2B_GAP:     s_d.b2b = pwdata_i[6:0];
				OFF_GAP_LOW:     s_d.gapl = pwdata_i[6:0];
				OFF_GAP_HIGH:    s_d.gaph = pwdata_i[6:0];
				OFF_RETRY_LIMIT: s_d.rlim = pwdata_i[3:0];
				OFF_COLL_WINDOW: s_d.cwin = pwdata_i[5:0];
				default: ;
			endcase
		end

		if (s_q.pause_cnt != 22'h000000)
			s_d.pause_cnt = s_q.pause_cnt - 22'h000001;

		// transmit path
		case (s_q.ts)
			TX_IDLE: begin
				// a frame may not start while a pause is being honoured
				if (tx_valid_i && s_q.pause_cnt == 22'h000000) begin
					s_d.tsv = 8'h00;
					s_d.tcnt = 16'h0000;
					s_d.tcrc = CRC_INIT;
					s_d.wait_cnt = 20'h00000;
					if (!full_dx && carrier_i) begin
						s_d.ts = TX_DEFER;
					end else begin
						s_d.ts = TX_DATA;
						s_d.tready = 1'b1;
					end
				end
			end
			TX_DEFER: begin
				if (!carrier_i) begin
					s_d.ts = TX_DATA;
					s_d.tready = 1'b1;
				end else if (!s_q.c4[BIT_WAIT_IDLE] &&
						s_q.wait_cnt == 20'(DEFER_LIMIT)) begin
					s_d.tsv[TS_DEFER] = 1'b1;
					s_d.tsv_valid = 1'b1;
					s_d.tcoll = 1'b0;
					s_d.ts = TX_DROP;
					s_d.tready = 1'b1;
				end else begin
					s_d.wait_cnt = s_q.wait_cnt + 20'h00001;
				end
			end
			TX_DATA: begin
				dlen = s_q.tcnt + 16'h0001 - hdr_len;
				if (!full_dx && collision_i) begin
					s_d.ptx_err = 1'b1;
					s_d.tsv[TS_COLLISION] = 1'b1;
					if (tx_valid_i && tx_last_i) begin
						s_d.tready = 1'b0;
						coll_go = 1'b1;
					end else begin
						s_d.tcoll = 1'b1;
						s_d.ts = TX_DROP;
					end
				end else if (tx_valid_i) begin
					s_d.tcnt = s_q.tcnt + 16'h0001;
					if (s_q.tcnt >= hdr_len) begin
						s_d.tcrc = crc_byte(s_q.tcrc, tx_data_i);
						if (s_q.tcnt - hdr_len == POS_TYPE_HI)
							s_d.ttype[15:8] = tx_data_i;
						if (s_q.tcnt - hdr_len == POS_TYPE_LO)
							s_d.ttype[7:0] = tx_data_i;
					end
					if (!s_q.c3[BIT_OVERSIZE] && dlen > s_q.mfl) begin
						s_d.ptx_err = 1'b1;
						s_d.tsv[TS_OVERSIZE] = 1'b1;
						s_d.tsv_valid = 1'b1;
						s_d.tcoll = 1'b0;
						if (tx_last_i) begin
							s_d.tready = 1'b0;
							go_ipg = 1'b1;
						end else begin
							s_d.ts = TX_DROP;
						end
					end else begin
						s_d.ptx_valid = 1'b1;
						s_d.ptx_data = tx_data_i;
						if (tx_last_i) begin
							s_d.tready = 1'b0;
							tgt = pad_target(s_q.c3[PAD_LSB+:3],
								s_q.ttype == TYPE_VLAN);
							s_d.ttarget = tgt;
							if (s_q.c3[BIT_LEN_CHECK] && len_mismatch(s_q.ttype,
									dlen, !s_q.c3[BIT_CRC_APPEND]))
								s_d.tsv[TS_LEN_MIS] = 1'b1;
							if (dlen < tgt) begin
								s_d.ts = TX_PAD;
							end else if (s_q.c3[BIT_CRC_APPEND]) begin
								s_d.ts = TX_CRC;
								s_d.crc_idx = 2'h0;
							end else begin
								// host supplied the fcs; residue must match
								s_d.tsv[TS_CRC_BAD] = crc_byte(s_q.tcrc,
									tx_data_i) != CRC_RESIDUE;
								s_d.ptx_last = 1'b1;
								fin = 1'b1;
							end
						end
					end
				end
			end
			TX_PAD: begin
				dlen = s_q.tcnt + 16'h0001 - hdr_len;
				s_d.tsv[TS_PADDED] = 1'b1;
				if (!full_dx && collision_i) begin
					s_d.ptx_err = 1'b1;
					s_d.tsv[TS_COLLISION] = 1'b1;
					coll_go = 1'b1;
				end else begin
					s_d.ptx_valid = 1'b1;
					s_d.ptx_data = 8'h00;
					s_d.tcnt = s_q.tcnt + 16'h0001;
					s_d.tcrc = crc_byte(s_q.tcrc, 8'h00);
					if (dlen >= s_q.ttarget) begin
						if (s_q.c3[BIT_CRC_APPEND]) begin
							s_d.ts = TX_CRC;
							s_d.crc_idx = 2'h0;
						end else begin
							s_d.ptx_last = 1'b1;
							fin = 1'b1;
						end
					end
				end
			end
			TX_CRC: begin
				s_d.tsv[TS_CRC_ADDED] = 1'b1;
				if (!full_dx && collision_i) begin
					s_d.ptx_err = 1'b1;
					s_d.tsv[TS_COLLISION] = 1'b1;
					coll_go = 1'b1;
				end else begin
					s_d.ptx_valid = 1'b1;
					s_d.ptx_data = ~s_q.tcrc[7:0];
					s_d.tcrc = s_q.tcrc >> 8;
					s_d.crc_idx = s_q.crc_idx + 2'h1;
					if (s_q.crc_idx == CRC_LAST) begin
						s_d.ptx_last = 1'b1;
						fin = 1'b1;
					end
				end
			end
			TX_DROP: begin
				// swallow the rest of an aborted frame from the source
				if (tx_valid_i && tx_last_i) begin
					s_d.tready = 1'b0;
					if (s_q.tcoll)
						coll_go = 1'b1;
					else
						go_ipg = 1'b1;
				end
			end
			TX_IPG, TX_BACKOFF: begin
				if (s_q.wait_cnt == 20'h00000)
					s_d.ts = TX_IDLE;
				else
					s_d.wait_cnt = s_q.wait_cnt - 20'h00001;
			end
			default: s_d.ts = TX_IDLE;
		endcase

		if (fin) begin
			s_d.tsv_valid = 1'b1;
			s_d.attempts = 4'h0;
			go_ipg = 1'b1;
		end
		if (coll_go) begin
			s_d.tsv_valid = 1'b1;
			if (s_q.attempts >= s_q.rlim) begin
				s_d.tsv[TS_RETRY_OUT] = 1'b1;
				s_d.attempts = 4'h0;
				go_ipg = 1'b1;
			end else begin
				s_d.attempts = s_q.attempts + 4'h1;
				s_d.ts = TX_BACKOFF;
				s_d.wait_cnt = bo_len;
			end
		end
		if (go_ipg) begin
			s_d.ts = TX_IPG;
			s_d.wait_cnt = ipg_len;
		end

		// receive path
		if (rx_valid_i) begin
			if (!s_q.ract) begin
				// enable is sampled once, on the first byte of a frame
				s_d.rgood = s_q.c1[BIT_RX_ENABLE];
				s_d.rdrop = !s_q.c1[BIT_RX_ENABLE];
				s_d.rcnt = 16'h0000;
				s_d.rcrc = CRC_INIT;
				s_d.rsv = 8'h00;
			end
			s_d.ract = !rx_last_i;
			if (s_d.rcnt >= hdr_len) begin
				s_d.rcrc = crc_byte(s_d.rcrc, rx_data_i);
				case (s_d.rcnt - hdr_len)
					POS_TYPE_HI:   s_d.rtype[15:8] = rx_data_i;
					POS_TYPE_LO:   s_d.rtype[7:0] = rx_data_i;
					POS_OP_HI:     s_d.rop[15:8] = rx_data_i;
					POS_OP_LO:     s_d.rop[7:0] = rx_data_i;
					POS_QUANTA_HI: s_d.rquanta[15:8] = rx_data_i;
					POS_QUANTA_LO: s_d.rquanta[7:0] = rx_data_i;
					default: ;
				endcase
			end
			dlen = s_d.rcnt + 16'h0001 - hdr_len;
			s_d.rcnt = s_d.rcnt + 16'h0001;
			if (!s_d.rdrop) begin
				s_d.rout_valid = 1'b1;
				s_d.rout_data = rx_data_i;
				s_d.rout_last = rx_last_i;
				if (!s_q.c3[BIT_OVERSIZE] && dlen > s_q.mfl) begin
					s_d.rout_last = 1'b1;
					s_d.rout_abort = 1'b1;
					s_d.rdrop = 1'b1;
					s_d.rsv[RS_OVERSIZE] = 1'b1;
					s_d.rsv[RS_DISCARD] = 1'b1;
					// status rides with the abort, never after the stream
					s_d.rsv_valid = 1'b1;
					s_d.rgood = 1'b0;
				end
			end
			if (rx_last_i && s_d.rgood) begin
				s_d.rsv_valid = 1'b1;
				s_d.rsv[RS_CRC_OK] = s_d.rcrc == CRC_RESIDUE;
				s_d.rsv[RS_LEN_MIS] = s_q.c3[BIT_LEN_CHECK] &&
					len_mismatch(s_d.rtype, dlen, 1'b1);
				s_d.rsv[RS_CONTROL] = s_d.rtype == TYPE_CONTROL;
				s_d.rsv[RS_PAUSE] = s_d.rsv[RS_CONTROL] &&
					s_d.rop == OPCODE_PAUSE;
				// control frames are flagged for discard unless passed through
				s_d.rsv[RS_DISCARD] = s_d.rsv[RS_OVERSIZE] ||
					(s_d.rsv[RS_CONTROL] &&
					!s_q.c1[BIT_PASSTHROUGH]);
				if (s_d.rsv[RS_PAUSE] && s_d.rsv[RS_CRC_OK] && full_dx &&
						s_q.c1[BIT_PAUSE_RX])
					s_d.pause_cnt = 22'(s_d.rquanta) * PAUSE_QUANTUM;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.c1 <= CTRL_RESET;
			s_q.c3 <= CTRL_RESET;
			s_q.c4 <= CTRL_RESET;
			s_q.mfl <= MAX_FRAME_RESET;
			s_q.b2b <= GAP_RESET;
			s_q.gapl <= GAP_RESET;
			s_q.gaph <= GAP_RESET;
			s_q.rlim <= RETRY_RESET;
			s_q.cwin <= WINDOW_RESET;
			s_q.lfsr <= LFSR_SEED;
			s_q.ts <= TX_IDLE;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign prdata_o          = s_q.prdata;
	assign pready_o          = s_q.pready;
	assign pslverr_o         = s_q.pslverr;
	assign tx_ready_o        = s_q.tready;
	assign phy_tx_valid_o    = s_q.ptx_valid;
	assign phy_tx_data_o     = s_q.ptx_data;
	assign phy_tx_last_o     = s_q.ptx_last;
	assign phy_tx_err_o      = s_q.ptx_err;
	assign tx_status_valid_o = s_q.tsv_valid;
	assign tx_status_o       = s_q.tsv;
	assign rx_out_valid_o    = s_q.rout_valid;
	assign rx_out_data_o     = s_q.rout_data;
	assign rx_out_last_o     = s_q.rout_last;
	assign rx_out_abort_o    = s_q.rout_abort;
	assign rx_status_valid_o = s_q.rsv_valid;
	assign rx_status_o       = s_q.rsv;
	assign pause_frame_req_o = s_q.pause_req;
	assign full_duplex_o     = s_q.c3[BIT_DUPLEX];

endmodule
`default_nettype wire

// *** mac_frame_control_config_props.sv ***
// concurrent checks on the ports of the mac frame control block
`timescale 1ns/1ps
`default_nettype none
module mac_frame_control_config_props (
	input wire logic        core_clk_i,
	input wire logic        srst_i,
	input wire logic        ce_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pause_send_i,
	input wire logic        pause_frame_req_o,
	input wire logic        full_duplex_o,
	input wire logic        phy_tx_last_o,
	input wire logic        tx_status_valid_o,
	input wire logic        rx_valid_i,
	input wire logic        rx_out_valid_o,
	input wire logic        rx_out_last_o,
	input wire logic        rx_status_valid_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	a_ctrl_one_zero: assert property (
		pready_o && !pwrite_i && paddr_i == 8'h00 |-> prdata_o[31:4] == 0)
		else $error("control one unused bits not zero");
	a_ctrl_four_zero: assert property (
		pready_o && !pwrite_i && paddr_i == 8'h08
		|-> (prdata_o & ~32'h70) == 0)
		else $error("control four unused bits not zero");
	a_ready_after_setup: assert property (
		ce_i && psel_i && !penable_i |=> pready_o)
		else $error("no answer after setup");
	a_pause_req_cause: assert property (
		pause_frame_req_o |-> $past(pause_send_i))
		else $error("pause request without cause");
	a_duplex_by_write: assert property (
		$changed(full_duplex_o) |-> $past(pready_o && pwrite_i &&
		paddr_i == 8'h04) || $past(pready_o && pwrite_i &&
		paddr_i == 8'h04, 2))
		else $error("duplex changed without write");
	a_rx_copy_cause: assert property (
		rx_out_valid_o |-> $past(rx_valid_i))
		else $error("rx byte forwarded without input");
	a_rx_status_last: assert property (
		rx_status_valid_o |-> rx_out_last_o)
		else $error("rx status apart from last byte");
	a_tx_status_last: assert property (
		phy_tx_last_o |-> tx_status_valid_o)
		else $error("tx status missing at last byte");
endmodule
bind mac_frame_control_config mac_frame_control_config_props i_props (.*);
`default_nettype wire

// *** mac_frame_control_config_tb.sv ***
// self-checking testbench for the mac frame control block
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, s) begin tests_run++; if ((s) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module mac_frame_control_config_tb
	import mac_frame_control_pkg::*;
;
	logic        core_clk_i, srst_i, ce_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i, tx_data_i, rx_data_i, phy_tx_data_o;
	logic [7:0]  tx_status_o, rx_out_data_o, rx_status_o, ts, rs;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, er, tx_valid_i, tx_last_i, tx_ready_o;
	logic        carrier_i, collision_i, backpressure_i, pause_send_i;
	logic        phy_tx_valid_o, phy_tx_last_o, phy_tx_err_o;
	logic        tx_status_valid_o, rx_valid_i, rx_last_i, rx_out_valid_o;
	logic        rx_out_last_o, rx_out_abort_o, rx_status_valid_o;
	logic        pause_frame_req_o, full_duplex_o, sv, rv;
	logic [2:0]  cd;
	int          num_errors, tests_run, nb, c, t;

	// short deferral limit keeps the abort case quick
	mac_frame_control_config #(.DEFER_LIMIT(20), .SLOT_CYCLES(2)) i_dut (.*);
	mac_phy_model i_phy (
		.clk_i     (core_clk_i),
		.srst_i    (srst_i),
		.tx_valid_i(phy_tx_valid_o),
		.tx_data_i (phy_tx_data_o),
		.tx_last_i (phy_tx_last_o),
		.tx_err_i  (phy_tx_err_o),
		.rx_valid_o(rx_valid_i),
		.rx_data_o (rx_data_i),
		.rx_last_o (rx_last_i)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		if (phy_tx_valid_o === 1'b1)
			nb++;
		if (tx_status_valid_o === 1'b1) begin
			sv = 1'b1;
			ts = tx_status_o;
		end
		if (rx_status_valid_o === 1'b1) begin
			rv = 1'b1;
			rs = rx_status_o;
		end
	end

	task tally_and_finish;
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		`chk(nm, e, rd)
	endtask

	function automatic logic [7:0] fb(input int i, input logic vl);
		if (vl && i == 12)
			return 8'h81;
		if (vl && i == 13)
			return 8'h00;
		return i[7:0] + 8'h01;
	endfunction

	task send(input int n, input logic vl);
		int i, k;
		i = 0;
		k = 0;
		nb = 0;
		sv = 1'b0;
		rv = 1'b0;
		ts = 8'h00;
		rs = 8'h00;
		while (i < n) begin
			tx_valid_i <= 1'b1;
			tx_data_i <= fb(i, vl);
			tx_last_i <= (i == n - 1);
			@(posedge core_clk_i);
			if (tx_ready_o === 1'b1)
				i++;
		end
		tx_valid_i <= 1'b0;
		tx_last_i <= 1'b0;
		for (k = 0; k < 300 && !sv; k++)
			@(posedge core_clk_i);
	endtask

	task wait_rx;
		for (int k = 0; k < 300 && !rv; k++)
			@(posedge core_clk_i);
	endtask

	initial begin
		{psel_i, penable_i, pwrite_i, tx_valid_i, tx_last_i} = '0;
		{carrier_i, collision_i, backpressure_i, pause_send_i} = '0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		tx_data_i = 8'h00;
		ce_i = 1'b1;
		srst_i = 1'b1;
		repeat (10) @(posedge core_clk_i);
		srst_i <= 1'b0;
		rdchk(OFF_CTRL_THREE, 32'h0, "ctrl3");
		rdchk(OFF_MAX_FRAME, 32'h5EE, "maxfl");
		apb(1'b0, 8'h40, 32'h0);
		`chk("slverr", 1'b1, er)
		apb(1'b1, OFF_CTRL_ONE, 32'hFF);
		rdchk(OFF_CTRL_ONE, 32'h0F, "ctrl1");
		apb(1'b1, OFF_CTRL_FOUR, 32'hFF);
		rdchk(OFF_CTRL_FOUR, 32'h70, "ctrl4");
		apb(1'b1, OFF_CTRL_FOUR, 32'h0);
		apb(1'b1, OFF_B2B_GAP, 32'h15);
		apb(1'b1, OFF_GAP_LOW, 32'h12);
		apb(1'b1, OFF_CTRL_THREE, 32'h11);
		`chk("fulldx", 1'b1, full_duplex_o)
		for (c = 0; c < 2; c++) begin
			apb(1'b1, OFF_CTRL_ONE, 32'(c * 8 + 1));
			pause_send_i <= 1'b1;
			repeat (3) @(posedge core_clk_i);
			`chk("pause", c[0], pause_frame_req_o)
			pause_send_i <= 1'b0;
		end
		// every pad code with append set, then a tagged frame
		for (c = 0; c < 9; c++) begin
			cd = (c == 8) ? PAD_VLAN : c[2:0];
			apb(1'b1, OFF_CTRL_THREE, {24'h0, cd, 5'h11});
			send(20, c == 8);
			t = 20;
			if (cd == PAD_60 || cd == PAD_VLAN)
				t = 60;
			if (cd == PAD_64_A || cd == PAD_64_B || c == 8)
				t = 64;
			`chk("txlen", t + 4, nb)
			wait_rx;
			`chk("rxcrc", 1'b1, rs[RS_CRC_OK])
		end
		apb(1'b1, OFF_CTRL_ONE, 32'h0);
		apb(1'b1, OFF_CTRL_THREE, 32'h01);
		send(20, 1'b0);
		`chk("nocrc", 20, nb)
		`chk("crcbad", 1'b1, ts[TS_CRC_BAD])
		wait_rx;
		`chk("rxoff", 1'b0, rv)
		apb(1'b1, OFF_CTRL_ONE, 32'h01);
		apb(1'b1, OFF_MAX_FRAME, 32'h40);
		send(80, 1'b0);
		`chk("ovsize", 1'b1, ts[TS_OVERSIZE])
		apb(1'b1, OFF_CTRL_THREE, 32'h15);
		send(80, 1'b0);
		`chk("huge", 84, nb)
		// oversize off again while the echo of the long frame arrives
		apb(1'b1, OFF_CTRL_THREE, 32'h11);
		wait_rx;
		`chk("rxbig", 1'b1, rs[RS_OVERSIZE])
		apb(1'b1, OFF_CTRL_THREE, 32'h10);
		carrier_i <= 1'b1;
		send(20, 1'b0);
		`chk("defer", 1'b1, ts[TS_DEFER])
		carrier_i <= 1'b0;
		apb(1'b1, OFF_CTRL_FOUR, 32'h10);
		collision_i <= 1'b1;
		send(20, 1'b0);
		collision_i <= 1'b0;
		`chk("coll", 1'b1, ts[TS_COLLISION])
		rdchk(OFF_STATUS, 32'h10, "tries");
		tally_and_finish();
	end

	initial begin
		repeat (50000) @(posedge core_clk_i);
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** mac_frame_control_pkg.sv ***
// constants, types and register map of the mac frame control block
// Overview of operation
// - receive only while receive enable set
// - pause transmit request only when enabled
// - honour received pause by inhibiting transmit
// - control frames discarded unless passthrough set
// - pad codes 111/011 pad to 64, crc
// - code 101: vlan pads 64, others 60
// - code 001 pads to 60, then crc
// - codes 110/100/010/000 never pad
// - crc append bit forces crc on all frames
// - no append: check last four bytes
// - vendor header excluded from crc
// - oversize frames aborted unless enabled
// - length field compared, mismatch reported
// - duplex bit selects full or half duplex
// - wait-for-idle defers forever, else limit abort
// - backpressure collision skips backoff when set
// - no-backoff bit retries at once
// - unimplemented bits read zero, reserved kept zero
// - gap is nibbles minus three or six
package mac_frame_control_pkg;

	localparam logic [7:0] OFF_CTRL_ONE    = 8'h00;
	localparam logic [7:0] OFF_CTRL_THREE  = 8'h04;
	localparam logic [7:0] OFF_CTRL_FOUR   = 8'h08;
	localparam logic [7:0] OFF_MAX_FRAME   = 8'h0C;
	localparam logic [7:0] OFF_B2B_GAP     = 8'h10;
	localparam logic [7:0] OFF_GAP_LOW     = 8'h14;
	localparam logic [7:0] OFF_GAP_HIGH    = 8'h18;
	localparam logic [7:0] OFF_RETRY_LIMIT = 8'h1C;
	localparam logic [7:0] OFF_COLL_WINDOW = 8'h20;
	localparam logic [7:0] OFF_STATUS      = 8'h24;

	// control register one
	localparam int BIT_RX_ENABLE   = 0;
	localparam int BIT_PASSTHROUGH = 1;
	localparam int BIT_PAUSE_RX    = 2;
	localparam int BIT_PAUSE_TX    = 3;
	localparam logic [7:0] CTRL_ONE_WMASK = 8'h0F;
	// control register three
	localparam int BIT_DUPLEX      = 0;
	localparam int BIT_LEN_CHECK   = 1;
	localparam int BIT_OVERSIZE    = 2;
	localparam int BIT_VENDOR_HDR  = 3;
	localparam int BIT_CRC_APPEND  = 4;
	localparam int PAD_LSB         = 5;
	// control register four
	localparam int BIT_NO_BACKOFF  = 4;
	localparam int BIT_BP_NO_BKOFF = 5;
	localparam int BIT_WAIT_IDLE   = 6;
	localparam logic [7:0] CTRL_FOUR_WMASK = 8'h70;

	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [15:0] MAX_FRAME_DEFAULT = 16'h05EE;
	localparam logic [6:0]  GAP_RESET       = 7'h00;
	localparam logic [3:0]  RETRY_RESET     = 4'hF;
	localparam logic [5:0]  WINDOW_RESET    = 6'h37;
	localparam logic [9:0]  LFSR_SEED       = 10'h2A5;

	localparam logic [2:0] PAD_64_A = 3'h7;
	localparam logic [2:0] PAD_VLAN = 3'h5;
	localparam logic [2:0] PAD_64_B = 3'h3;
	localparam logic [2:0] PAD_60   = 3'h1;

	localparam logic [15:0] TYPE_VLAN     = 16'h8100;
	localparam logic [15:0] TYPE_CONTROL  = 16'h8808;
	localparam logic [15:0] OPCODE_PAUSE  = 16'h0001;
	localparam logic [15:0] LENGTH_MAX    = 16'h05DC;
	localparam logic [15:0] FRAME_MIN     = 16'h003C;
	localparam logic [15:0] FRAME_MIN_TAG = 16'h0040;
	localparam logic [15:0] PAYLOAD_MIN   = 16'h002E;
	localparam logic [15:0] HDR_BYTES     = 16'h0004;
	localparam logic [15:0] FCS_BYTES     = 16'h0004;
	localparam logic [15:0] MAC_HDR_BYTES = 16'h000E;
	localparam logic [15:0] LEN_CHECK_MIN = 16'h0012;
	localparam logic [15:0] POS_TYPE_HI   = 16'h000C;
	localparam logic [15:0] POS_TYPE_LO   = 16'h000D;
	localparam logic [15:0] POS_OP_HI     = 16'h000E;
	localparam logic [15:0] POS_OP_LO     = 16'h000F;
	localparam logic [15:0] POS_QUANTA_HI = 16'h0010;
	localparam logic [15:0] POS_QUANTA_LO = 16'h0011;

	localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
	localparam logic [1:0]  CRC_LAST    = 2'h3;

	localparam logic [19:0] GAP_OFS_FULL = 20'h00003;
	localparam logic [19:0] GAP_OFS_HALF = 20'h00006;
	localparam logic [21:0] PAUSE_QUANTUM = 22'h000040;
	localparam logic [3:0]  BACKOFF_CAP   = 4'hA;
	localparam int DEFER_LIMIT_DEFAULT = 3036;
	localparam int SLOT_CYCLES_DEFAULT = 64;

	// transmit status vector bits
	localparam int TS_CRC_BAD   = 0;
	localparam int TS_LEN_MIS   = 1;
	localparam int TS_OVERSIZE  = 2;
	localparam int TS_DEFER     = 3;
	localparam int TS_COLLISION = 4;
	localparam int TS_RETRY_OUT = 5;
	localparam int TS_CRC_ADDED = 6;
	localparam int TS_PADDED    = 7;
	// receive status vector bits
	localparam int RS_CRC_OK    = 0;
	localparam int RS_LEN_MIS   = 1;
	localparam int RS_OVERSIZE  = 2;
	localparam int RS_CONTROL   = 3;
	localparam int RS_PAUSE     = 4;
	localparam int RS_DISCARD   = 5;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_DEFER,
		TX_DATA,
		TX_PAD,
		TX_CRC,
		TX_DROP,
		TX_IPG,
		TX_BACKOFF
	} tx_state_t;

endpackage

// *** mac_phy_model.sv ***
// line-side model: remote node that echoes each finished frame back
`timescale 1ns/1ps
`default_nettype none
module mac_phy_model (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	input  wire logic       tx_err_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_last_o
);
	logic [7:0] mem [0:127];
	int         wr, rd, len;
	// idle data toggles so a stale byte never looks valid
	always @(posedge clk_i) begin
		rx_valid_o <= 1'b0;
		rx_last_o <= 1'b0;
		rx_data_o <= ~rx_data_o;
		if (srst_i) begin
			rx_data_o <= 8'h5A;
			wr <= 0;
			rd <= 0;
			len <= 0;
		end else begin
			if (tx_valid_i) begin
				mem[wr[6:0]] <= tx_data_i;
				wr <= wr + 1;
			end
			if (tx_err_i || tx_last_i)
				wr <= 0;
			// aborted frames are not echoed
			if (tx_last_i && !tx_err_i) begin
				len <= wr + 1;
				rd <= 0;
			end else if (rd < len) begin
				rx_valid_o <= 1'b1;
				rx_data_o <= mem[rd[6:0]];
				rx_last_o <= (rd == len - 1);
				rd <= rd + 1;
			end
		end
	end
endmodule
`default_nettype wire
